// file: crcsp_port.v
/*
 * Serial slave port with check byte protection in front of an 8-bit
 * register file. Frames are sampled by the 200 MHz system clock, which
 * oversamples the serial clock pin. Writes leave through a small FIFO.
 * Assumes the register file answers hit, write mask and read data
 * combinationally for the address on REG_ADDR_OUT, on this clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "crcsp_defs.vh"
module crcsp_port
#(
    parameter FIFO_DEPTH = `CRCSP_FIFO_DEPTH,
    parameter FIFO_AW    = 2
)
(
    input  wire       CLOCK_IN,
    input  wire       RST_IN,
    input  wire       CS_N_IN,
    input  wire       SCK_IN,
    input  wire       SERIAL_IN_IN,
    output wire       SERIAL_OUT_OUT,
    output wire       SERIAL_OUT_OE_OUT,
    input  wire       UV_IN,
    output wire [4:0] REG_ADDR_OUT,
    input  wire       REG_HIT_IN,
    input  wire [7:0] REG_WMASK_IN,
    input  wire [7:0] REG_RDATA_IN,
    output wire       WR_VALID_OUT,
    input  wire       WR_READY_IN,
    output wire [4:0] WR_ADDR_OUT,
    output wire [7:0] WR_DATA_OUT,
    output wire [7:0] WR_MASK_OUT,
    output wire       COMM_ERR_OUT
);
    localparam FW = `CRCSP_ADDR_W + 16;

    // --------------------------------------------------------------
    // Check byte helpers
    // --------------------------------------------------------------
    function [7:0] crc_step;
        input [7:0] crc;
        input       bit_in;
        reg         fb;
        begin
            fb       = crc[7] ^ bit_in;
            crc_step = {crc[6:0], 1'b0} ^ (fb ? `CRCSP_CRC_POLY : 8'h00); // see [R18] [R26]
        end
    endfunction

    function [7:0] crc_byte;
        input [7:0] data;
        integer     i;
        reg [7:0]   c;
        begin
            c = `CRCSP_CRC_INIT;
            for (i = 7; i >= 0; i = i - 1)
            begin
                c = crc_step(c, data[i]); // see [R4]
            end
            crc_byte = c;
        end
    endfunction

    // --------------------------------------------------------------
    // Pin synchronisers
    // --------------------------------------------------------------
    // Reset levels match the pad pulls: deselected, clock and data low.
    reg cs_n_m_q;
    reg cs_n_s_q;
    reg sck_m_q;
    reg sck_s_q;
    reg sck_d_q;
    reg sdi_m_q;
    reg sdi_s_q;
    reg uv_m_q;
    reg uv_s_q;
    reg cs_n_d_q;

    always @(posedge CLOCK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            cs_n_m_q <= `CRCSP_CS_N_RST;   // see [R21]
            cs_n_s_q <= `CRCSP_CS_N_RST;
            cs_n_d_q <= `CRCSP_CS_N_RST;
            sck_m_q  <= `CRCSP_PULLDN_RST; // see [R21]
            sck_s_q  <= `CRCSP_PULLDN_RST;
            sck_d_q  <= `CRCSP_PULLDN_RST;
            sdi_m_q  <= `CRCSP_PULLDN_RST; // see [R21]
            sdi_s_q  <= `CRCSP_PULLDN_RST;
            uv_m_q   <= 1'b0;
            uv_s_q   <= 1'b0;
        end
        else
        begin
            cs_n_m_q <= CS_N_IN;
            cs_n_s_q <= cs_n_m_q;
            cs_n_d_q <= cs_n_s_q;
            sck_m_q  <= SCK_IN;
            sck_s_q  <= sck_m_q;
            sck_d_q  <= sck_s_q;
            sdi_m_q  <= SERIAL_IN_IN;
            sdi_s_q  <= sdi_m_q;
            uv_m_q   <= UV_IN;
            uv_s_q   <= uv_m_q;
        end
    end

    wire selected  = ~cs_n_s_q;
    wire cs_fall   = ~cs_n_s_q & cs_n_d_q;
    wire cs_rise   = cs_n_s_q & ~cs_n_d_q;
    wire sck_rise  = selected & ~cs_fall & sck_s_q & ~sck_d_q;  // see [R1]
    wire sck_fall  = selected & ~cs_fall & ~sck_s_q & sck_d_q;  // see [R1]

    // --------------------------------------------------------------
    // Receive side
    // --------------------------------------------------------------
    reg [5:0]  rx_cnt_q;
    reg [23:0] rx_sh_q;
    reg [7:0]  crc_calc_q;
    reg        hdr_done_q;
    reg        hit_q;
    reg [7:0]  wmask_q;
    reg [4:0]  addr_q;

    wire       rx_rw   = rx_sh_q[23];
    wire       in_crc  = (rx_cnt_q < `CRCSP_HDR_BITS);

    always @(posedge CLOCK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            rx_cnt_q   <= 6'd0;
            rx_sh_q    <= 24'h00_0000;
            crc_calc_q <= `CRCSP_CRC_INIT;
            hdr_done_q <= 1'b0;
            hit_q      <= 1'b0;
            wmask_q    <= 8'h00;
            addr_q     <= 5'd0;
        end
        else if (cs_fall)
        begin
            rx_cnt_q   <= 6'd0;
            rx_sh_q    <= 24'h00_0000;
            crc_calc_q <= `CRCSP_CRC_INIT; // see [R26]
            hdr_done_q <= 1'b0;
        end
        else
        begin
            if (sck_fall)
            begin
                if (rx_cnt_q != 6'd63)
                begin
                    rx_cnt_q <= rx_cnt_q + 6'd1; // see [R6]
                end
                if (rx_cnt_q < `CRCSP_RXCRC_END)
                begin
                    rx_sh_q <= {rx_sh_q[22:0], sdi_s_q}; // see [R2] [R4]
                end
                if (in_crc)
                begin
                    crc_calc_q <= crc_step(crc_calc_q, sdi_s_q); // see [R10] [R15] [R20]
                end
            end
            if (!hdr_done_q && rx_cnt_q >= `CRCSP_ADDR_END)
            begin
                // Operation bit and five address bits are in
                hdr_done_q <= 1'b1;
                addr_q     <= rx_sh_q[4:0]; // see [R25]
                hit_q      <= REG_HIT_IN;
                wmask_q    <= REG_WMASK_IN;
            end
        end
    end

    assign REG_ADDR_OUT = hdr_done_q ? addr_q : rx_sh_q[4:0];

    wire [7:0] rx_data  = rx_sh_q[7:0];
    wire       crc_ok   = (rx_sh_q[7:0] == crc_calc_q);

    // --------------------------------------------------------------
    // Transmit side
    // --------------------------------------------------------------
    reg [39:0] tx_q;
    reg [5:0]  tx_cnt_q;
    reg        tx_bit_q;
    reg        crc_chk_q;
    reg        sdo_q;
    reg        oe_q;

    always @(posedge CLOCK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            tx_q      <= 40'h00_0000_0000;
            tx_cnt_q  <= 6'd0;
            tx_bit_q  <= `CRCSP_FILL;
            crc_chk_q <= 1'b0;
        end
        else if (cs_fall | cs_rise) // Line idles low between frames
        begin
            tx_q      <= 40'h00_0000_0000; // see [R11]
            tx_cnt_q  <= 6'd0;
            tx_bit_q  <= `CRCSP_FILL;
            crc_chk_q <= 1'b0;
        end
        else
        begin
            if (!hdr_done_q && rx_cnt_q >= `CRCSP_ADDR_END && !rx_sh_q[5])
            begin
                // Read reply built as soon as the address is known
                tx_q <= {8'h00, REG_RDATA_IN, 16'h0000, crc_byte(REG_RDATA_IN)}; // see [R8] [R16] [R17]
            end
            else if (!crc_chk_q && rx_cnt_q >= `CRCSP_RXCRC_END)
            begin
                crc_chk_q <= 1'b1;
                if (!rx_rw && !crc_ok)
                begin
                    tx_q[7:0] <= ~tx_q[7:0]; // see [R22]
                end
            end
            if (sck_rise)
            begin
                if (tx_cnt_q < `CRCSP_FRAME_BITS)
                begin
                    tx_bit_q <= tx_q[6'd39 - tx_cnt_q]; // see [R3] [R4]
                    tx_cnt_q <= tx_cnt_q + 6'd1;
                end
                else
                begin
                    tx_bit_q <= `CRCSP_FILL;
                end
            end
        end
    end

    always @(posedge CLOCK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            sdo_q <= 1'b0;
            oe_q  <= 1'b0;
        end
        else
        begin
            sdo_q <= uv_s_q ? 1'b0 : tx_bit_q; // see [R23]
            oe_q  <= selected;                 // see [R5]
        end
    end

    assign SERIAL_OUT_OUT    = sdo_q;
    assign SERIAL_OUT_OE_OUT = oe_q;

    // --------------------------------------------------------------
    // Frame end: commit, discard or flag
    // --------------------------------------------------------------
    reg          pend_q;
    reg [FW-1:0] pend_word_q;
    reg          err_q;
    wire         fifo_ready;
    wire         len_ok   = (rx_cnt_q == `CRCSP_FRAME_BITS);
    wire         good_wr  = len_ok & hit_q & rx_rw & crc_ok & ~uv_s_q;

    always @(posedge CLOCK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            pend_q      <= 1'b0;
            pend_word_q <= {FW{1'b0}};
            err_q       <= 1'b0;
        end
        else
        begin
            err_q <= 1'b0;
            if (pend_q && fifo_ready)
            begin
                pend_q <= 1'b0;
            end
            if (cs_rise && !uv_s_q)
            begin
                if (!len_ok || !hit_q)
                begin
                    err_q <= 1'b1; // see [R24]
                end
                else if (good_wr)
                begin
                    if (pend_q && !fifo_ready)
                    begin
                        // Previous write still stalled: refuse this one
                        err_q <= 1'b1;
                    end
                    else
                    begin
                        pend_q      <= 1'b1; // see [R7] [R9] [R19]
                        pend_word_q <= {addr_q, rx_sh_q[15:8] & wmask_q, wmask_q}; // see [R12]
                    end
                end
            end
        end
    end

    assign COMM_ERR_OUT = err_q;

    // --------------------------------------------------------------
    // Write queue toward the register file
    // --------------------------------------------------------------
    wire [FW-1:0] fifo_out;

    crcsp_fifo
    #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    )
    u_wr_fifo
    (
        .clk_in        (CLOCK_IN),
        .rst_in        (RST_IN),
        .in_valid_in   (pend_q),
        .in_ready_out  (fifo_ready),
        .in_data_in    (pend_word_q),
        .out_valid_out (WR_VALID_OUT),
        .out_ready_in  (WR_READY_IN),
        .out_data_out  (fifo_out)
    );

    assign WR_ADDR_OUT = fifo_out[FW-1:16];
    assign WR_DATA_OUT = fifo_out[15:8];
    assign WR_MASK_OUT = fifo_out[7:0];
endmodule
`default_nettype wire

// file: crcsp_defs.vh
/*
 * Constants of the checked serial register port: frame layout, check byte
 * generator, FIFO sizing and synchroniser reset levels.
 * Assumes it is included by bare name from the port and FIFO sources.
 */
// Function
// [R1] Frames only while chip select low; clock and data ignored otherwise.
// [R2] Host changes serial_in on rising clock; device samples on falling.
// [R3] Device updates serial_out on rising clock; host samples on falling.
// [R4] Both directions shift most significant bit first.
// [R5] serial_out push-pull while selected, high impedance when deselected.
// [R6] Each frame is exactly forty clock periods.
// [R7] First frame bit one means register write.
// [R8] First frame bit zero means register read.
// [R9] Write frame: op, address, 2 dummy, 8 data, 8 check, 16 dummy.
// [R10] Write check byte covers first sixteen frame bits.
// [R11] During writes serial_out carries only filler.
// [R12] Unimplemented register bits are never updated by writes.
// [R13] Host should read back after each write to confirm.
// [R14] Read frame: op, address, 10 dummy, 8 check, 16 dummy.
// [R15] Read check byte covers first sixteen frame bits.
// [R16] Read reply: 8 filler, 8 data, 16 filler, 8 check bits.
// [R17] Returned check byte covers only the eight returned data bits.
// [R18] All check bytes use generator x^8+x^4+x^3+x^2+1.
// [R19] Write with bad check byte is discarded, register unchanged.
// [R20] Dummy bits only matter for the check computation.
// [R21] Chip select pulled high, data and clock pulled low when undriven.
// [R22] Read with bad check byte returns a deliberately wrong check byte.
// [R23] Under supply undervoltage refuse frames and hold serial_out low.
// [R24] Unmapped address or length not forty sets communication error.
// [R25] Address field is five bits after the operation bit.
// [R26] Check register starts at zero, bits processed most significant first.
`ifndef CRCSP_DEFS_VH
`define CRCSP_DEFS_VH

`define CRCSP_FRAME_BITS   6'd40
`define CRCSP_ADDR_W       5
`define CRCSP_ADDR_END     6'd6
`define CRCSP_HDR_BITS     6'd16
`define CRCSP_RXCRC_END    6'd24
`define CRCSP_CRC_POLY     8'h1D
`define CRCSP_CRC_INIT     8'h00
`define CRCSP_FILL         1'b0
`define CRCSP_RD_DATA_MSB  6'd31
`define CRCSP_FIFO_DEPTH   4
`define CRCSP_CS_N_RST     1'b1
`define CRCSP_PULLDN_RST   1'b0

`endif

// file: crcsp_fifo.v
/*
 * Small synchronous FIFO built from flip-flops, valid/ready on both sides.
 * Assumes a single clock and an asynchronous active-high reset.
 */
`timescale 1ns/100ps
`default_nettype none
`include "crcsp_defs.vh"
module crcsp_fifo
#(
    parameter WIDTH = 21,
    parameter DEPTH = `CRCSP_FIFO_DEPTH,
    parameter AW    = 2
)
(
    input  wire             clk_in,
    input  wire             rst_in,
    input  wire             in_valid_in,
    output wire             in_ready_out,
    input  wire [WIDTH-1:0] in_data_in,
    output wire             out_valid_out,
    input  wire             out_ready_in,
    output wire [WIDTH-1:0] out_data_out
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_q;
    reg [AW-1:0]    rd_ptr_q;
    reg [AW:0]      count_q;
    wire            push;
    wire            pop;

    assign in_ready_out  = (count_q != DEPTH[AW:0]);
    assign out_valid_out = (count_q != {(AW+1){1'b0}});
    assign out_data_out  = mem_q[rd_ptr_q];
    assign push          = in_valid_in & in_ready_out;
    assign pop           = out_valid_out & out_ready_in;

    always @(posedge clk_in)
    begin
        if (push)
        begin
            mem_q[wr_ptr_q] <= in_data_in;
        end
    end

    always @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q  <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
            end
            if (push & ~pop)
            begin
                count_q <= count_q + 1'b1;
            end
            else if (pop & ~push)
            begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// file: crcsp_checker.sv
/* Concurrent checks on the pins of the serial register port.
   Assumes it is bound to crcsp_port: one clock, async high reset. */
`timescale 1ns/100ps
`default_nettype none
module crcsp_checker
(
    input wire logic       CLOCK_IN,
    input wire logic       RST_IN,
    input wire logic       CS_N_IN,
    input wire logic       SCK_IN,
    input wire logic       UV_IN,
    input wire logic       SERIAL_OUT_OUT,
    input wire logic       SERIAL_OUT_OE_OUT,
    input wire logic       WR_VALID_OUT,
    input wire logic       WR_READY_IN,
    input wire logic [4:0] WR_ADDR_OUT,
    input wire logic [7:0] WR_DATA_OUT,
    input wire logic [7:0] WR_MASK_OUT,
    input wire logic       COMM_ERR_OUT
);
default clocking cb @(posedge CLOCK_IN); endclocking
default disable iff (RST_IN);
a_oe_released: assert property (CS_N_IN [*6] |-> !SERIAL_OUT_OE_OUT)
    else $error("output enabled while deselected");
a_oe_driven: assert property (!CS_N_IN [*6] |-> SERIAL_OUT_OE_OUT)
    else $error("output not driven while selected");
a_uv_quiet: assert property (UV_IN [*5] |-> !SERIAL_OUT_OUT)
    else $error("output high under undervoltage");
a_uv_refused: assert property (UV_IN [*8] |-> !COMM_ERR_OUT && !$rose(WR_VALID_OUT))
    else $error("frame acted on under undervoltage");
a_out_on_rise: assert property (!CS_N_IN && SERIAL_OUT_OE_OUT
    && $past(SERIAL_OUT_OE_OUT) && $changed(SERIAL_OUT_OUT)
    |-> $past(SCK_IN, 3) || $past(SCK_IN, 4))
    else $error("output changed away from a clock rise");
a_err_pulse: assert property (COMM_ERR_OUT |=> !COMM_ERR_OUT)
    else $error("error pulse longer than one cycle");
a_err_frame_end: assert property (COMM_ERR_OUT |-> CS_N_IN && $past(CS_N_IN))
    else $error("error flagged inside a frame");
a_wr_frame_end: assert property ($rose(WR_VALID_OUT) |-> CS_N_IN)
    else $error("write queued inside a frame");
a_wr_held: assert property (WR_VALID_OUT && !WR_READY_IN |=>
    WR_VALID_OUT && $stable(WR_ADDR_OUT) && $stable(WR_DATA_OUT))
    else $error("queued write changed while stalled");
a_wr_masked: assert property (WR_VALID_OUT |-> (WR_DATA_OUT & ~WR_MASK_OUT) == 8'h00)
    else $error("write data outside mask");
c_err: cover property (COMM_ERR_OUT);
c_taken: cover property (WR_VALID_OUT && WR_READY_IN);
c_stall: cover property ((WR_VALID_OUT && !WR_READY_IN) [*8]);
endmodule
`default_nettype wire

// file: crcsp_host.sv
/* Behavioural serial bus master: builds checked frames and runs them.
   Assumes an 80 ns serial clock, unrelated to the system clock. */
`timescale 1ns/100ps
`default_nettype none
module crcsp_host
(
    output logic      cs_n_out,
    output logic      sck_out,
    output logic      sdi_out,
    input  wire logic sdo_in,
    input  wire logic oe_in
);
// ----------------
// Frame building
// ----------------
function automatic logic [7:0] crc8(input logic [15:0] d, input int n);
    logic [7:0] c;
    c = 8'h00;
    for (int i = n - 1; i >= 0; i--)
        c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h1D : 8'h00);
    return c;
endfunction
function automatic logic [39:0] frame(input logic rw, input logic [4:0] a,
                                      input logic [9:0] mid, input logic bad);
    logic [15:0] h;
    h = {rw, a, mid};
    return {h, crc8(h, 16) ^ {8{bad}}, 16'h0000};
endfunction
// ----------------
// Transfer
// ----------------
task automatic xfer(input logic [39:0] f, input int n, output logic [39:0] r);
    logic b;
    b = 1'b0;
    r = '0;
    // Pins move by non-blocking update so clock-edge sampling sees old values
    cs_n_out <= 1'b0;
    #40;
    for (int k = 0; k < n; k++)
    begin
        sdi_out <= f[39-k];
        sck_out <= 1'b1;
        #40;
        // Released line reads as the inverse of the last bit
        b = oe_in ? sdo_in : ~b;
        r[39-k] = b;
        sck_out <= 1'b0;
        #40;
    end
    sdi_out <= 1'b0;
    cs_n_out <= 1'b1;
    #200;
endtask
initial
begin
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    sdi_out = 1'b0;
end
endmodule
`default_nettype wire

// file: crc_checked_spi_register_port_tb.sv
/* Testbench of the serial register port: host model on the link,
   a small register file draining the write queue on the core side.
   Assumes the host model and checker are compiled before it. */
`timescale 1ns/100ps
`default_nettype none
module crc_checked_spi_register_port_tb;
logic        clk;
logic        rst;
logic        uv;
logic        wr_rdy;
wire         cs_n, sck, sdi, sdo, oe, wr_v, err;
wire  [4:0]  addr, wr_a;
wire  [7:0]  wr_d, wr_m;
logic [7:0]  regs [0:31];
logic [39:0] r;
int          n_fail = 0;
int          n_tests = 0;
int          n_err = 0;
int          n_wr = 0;
int          cyc = 0;
// Registers 1..8 mapped; register 2 implements bits 4..0 only
wire         hit = (addr >= 5'h01) && (addr <= 5'h08);
wire  [7:0]  msk = (addr == 5'h02) ? 8'h1F : 8'hFF;
crcsp_port i_dut
(
    .CLOCK_IN(clk), .RST_IN(rst), .CS_N_IN(cs_n), .SCK_IN(sck),
    .SERIAL_IN_IN(sdi), .SERIAL_OUT_OUT(sdo), .SERIAL_OUT_OE_OUT(oe),
    .UV_IN(uv), .REG_ADDR_OUT(addr), .REG_HIT_IN(hit), .REG_WMASK_IN(msk),
    .REG_RDATA_IN(regs[addr]), .WR_VALID_OUT(wr_v), .WR_READY_IN(wr_rdy),
    .WR_ADDR_OUT(wr_a), .WR_DATA_OUT(wr_d), .WR_MASK_OUT(wr_m), .COMM_ERR_OUT(err)
);
crcsp_host i_host
(
    .cs_n_out(cs_n), .sck_out(sck), .sdi_out(sdi), .sdo_in(sdo), .oe_in(oe)
);
initial
begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
end
always @(posedge clk)
begin
    cyc <= cyc + 1;
    if (err === 1'b1)
        n_err <= n_err + 1;
    if (wr_v === 1'b1 && wr_rdy === 1'b1)
    begin
        n_wr <= n_wr + 1;
        regs[wr_a] <= (regs[wr_a] & ~wr_m) | wr_d;
    end
    if (cyc == 30000)
    begin
        n_fail++;
        close_out;
    end
end
// ----------------
// Helpers
// ----------------
task automatic chk(input logic [39:0] g, input logic [39:0] e, input string m);
    n_tests++;
    if (g !== e)
    begin
        n_fail++;
        $display("wrong value at %0t: %s", $time, m);
    end
endtask
function automatic logic [39:0] rd(input logic [7:0] d, input logic bad);
    return {8'h00, d, 16'h0000, i_host.crc8({8'h00, d}, 8) ^ {8{bad}}};
endfunction
task automatic x(input logic rw, input logic [4:0] a, input logic [9:0] m,
                 input logic bad, input int n);
    i_host.xfer(i_host.frame(rw, a, m, bad), n, r);
endtask
task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
endtask
// ----------------
// Scenarios
// ----------------
task automatic t_wr_rd;
    x(1'b1, 5'h01, {2'b11, 8'hA5}, 1'b0, 40);
    chk(r, 40'h00_0000_0000, "write reply");
    x(1'b0, 5'h01, 10'h2AA, 1'b0, 40);
    chk(r, rd(8'hA5, 1'b0), "read back");
    x(1'b1, 5'h02, {2'b00, 8'hFF}, 1'b0, 40);
    x(1'b0, 5'h02, 10'h000, 1'b0, 40);
    chk(r, rd(8'h1F, 1'b0), "masked bits");
    $display("test wr_rd done");
endtask
task automatic t_bad;
    int e;
    e = n_err;
    x(1'b1, 5'h01, {2'b00, 8'h11}, 1'b1, 40);
    x(1'b0, 5'h01, 10'h000, 1'b0, 40);
    chk(r, rd(8'hA5, 1'b0), "bad write kept");
    x(1'b0, 5'h01, 10'h000, 1'b1, 40);
    chk(r, rd(8'hA5, 1'b1), "bad read check");
    chk(40'(n_err - e), 40'd0, "silent discard");
    $display("test bad done");
endtask
task automatic t_err;
    int e;
    int w;
    e = n_err;
    w = n_wr;
    x(1'b0, 5'h1F, 10'h000, 1'b0, 40);
    x(1'b1, 5'h00, {2'b00, 8'h77}, 1'b0, 40);
    x(1'b0, 5'h01, 10'h000, 1'b0, 39);
    chk(40'(n_err - e), 40'd3, "error count");
    chk(40'(n_wr - w), 40'd0, "no write");
    $display("test err done");
endtask
task automatic t_uv;
    int e;
    int w;
    e = n_err;
    w = n_wr;
    @(posedge clk);
    uv <= 1'b1;
    repeat (10) @(posedge clk);
    x(1'b1, 5'h01, {2'b00, 8'h3C}, 1'b0, 40);
    x(1'b0, 5'h01, 10'h000, 1'b0, 40);
    chk(r, 40'h00_0000_0000, "output low");
    @(posedge clk);
    uv <= 1'b0;
    repeat (10) @(posedge clk);
    x(1'b0, 5'h01, 10'h000, 1'b0, 40);
    chk(r, rd(8'hA5, 1'b0), "not committed");
    chk(40'(n_err - e + n_wr - w), 40'd0, "no action");
    $display("test uv done");
endtask
task automatic t_fifo;
    int e;
    int w;
    int i;
    e = n_err;
    w = n_wr;
    i = 0;
    @(posedge clk);
    wr_rdy <= 1'b0;
    while (i < 8 && n_err == e)
    begin
        i++;
        x(1'b1, 5'h03, {2'b00, 8'(i)}, 1'b0, 40);
    end
    chk(40'(n_err - e), 40'd1, "queue refused");
    chk(40'(i >= 5), 40'd1, "queue depth");
    @(posedge clk);
    wr_rdy <= 1'b1;
    for (int k = 0; k < 100 && wr_v !== 1'b0; k++)
        @(posedge clk);
    chk(40'(n_wr - w), 40'(i - 1), "drained");
    x(1'b0, 5'h03, 10'h000, 1'b0, 40);
    chk(r, rd(8'(i - 1), 1'b0), "last kept");
    $display("test fifo done");
endtask
initial
begin
    rst = 1'b1;
    uv = 1'b0;
    wr_rdy = 1'b1;
    foreach (regs[j])
        regs[j] = 8'h00;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    t_wr_rd;
    t_bad;
    t_err;
    t_uv;
    t_fifo;
    close_out;
end
endmodule
bind crcsp_port crcsp_checker i_chk
(
    .CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN), .CS_N_IN(CS_N_IN), .SCK_IN(SCK_IN),
    .UV_IN(UV_IN), .SERIAL_OUT_OUT(SERIAL_OUT_OUT), .SERIAL_OUT_OE_OUT(SERIAL_OUT_OE_OUT),
    .WR_VALID_OUT(WR_VALID_OUT), .WR_READY_IN(WR_READY_IN), .WR_ADDR_OUT(WR_ADDR_OUT),
    .WR_DATA_OUT(WR_DATA_OUT), .WR_MASK_OUT(WR_MASK_OUT), .COMM_ERR_OUT(COMM_ERR_OUT)
);
`default_nettype wire
